/* File: verilog/ils_pkg.sv */
// Shared constants and types of the issue and latency scheduler.
// Assumes one core clock; all latencies are counted in core clock cycles.

`default_nettype none

package ils_pkg;

   // ***********************************************************************
   // Operation classes seen at dispatch
   // ***********************************************************************
   typedef enum logic [3:0] {
      ILS_OP_NONE,
      ILS_OP_LINK_COUNT_MOVE,
      ILS_OP_XER_TO_COND,
      ILS_OP_COND_READ,
      ILS_OP_TIME_BASE_READ,
      ILS_OP_SPECIAL_READ,
      ILS_OP_FP_LOAD,
      ILS_OP_FP_LOAD_UPDATE,
      ILS_OP_FP_STORE,
      ILS_OP_FP_STORE_UPDATE,
      ILS_OP_FP_STORE_INT,
      ILS_OP_FP_ARITH
   } ils_op_type;

   // ***********************************************************************
   // Unit vector layout
   // ***********************************************************************
   localparam int ILS_UNIT_COUNT   = 4;
   localparam int ILS_UNIT_BRANCH  = 0;
   localparam int ILS_UNIT_FIXED   = 1;
   localparam int ILS_UNIT_LSU     = 2;
   localparam int ILS_UNIT_FLOAT   = 3;

   // ***********************************************************************
   // Register tags: bit 5 selects the floating-point file
   // ***********************************************************************
   localparam int ILS_TAG_WIDTH    = 6;
   localparam int ILS_REG_COUNT    = 64;
   localparam int ILS_TAG_FP_BIT   = 5;
   localparam int ILS_COUNT_WIDTH  = 6;

   // ***********************************************************************
   // Latencies and issue intervals in cycles
   // ***********************************************************************
   localparam int ILS_LAT_LINK_COUNT    = 1;
   localparam int ILS_LAT_XER_TO_COND   = 1;
   localparam int ILS_LAT_COND_READ     = 34;
   localparam int ILS_GAP_COND_READ     = 34;
   localparam int ILS_LAT_TIME_BASE     = 40;
   localparam int ILS_GAP_TIME_BASE     = 40;
   localparam int ILS_LAT_SPECIAL_READ  = 8;
   localparam int ILS_LAT_FP_LOAD       = 1;
   localparam int ILS_LAT_UPDATE_GPR    = 2;
   localparam int ILS_LAT_FP_ARITH      = 10;

   // Reset values
   localparam logic [ILS_COUNT_WIDTH-1:0] ILS_COUNT_RESET = 6'h00;
   localparam logic [ILS_UNIT_COUNT-1:0]  ILS_UNIT_RESET  = 4'h0;

endpackage

`default_nettype wire

/* File: verilog/ils_board_if.sv */
// Interface between the scheduler core and its result scoreboard.
// Assumes both ends sit on the same core clock.

`timescale 1ns/1ps
`default_nettype none

interface ils_board_if
   import ils_pkg::*;
   ();
   logic                       set_a_valid;
   logic [ILS_TAG_WIDTH-1:0]   set_a_tag;
   logic [ILS_COUNT_WIDTH-1:0] set_a_count;
   logic                       set_b_valid;
   logic [ILS_TAG_WIDTH-1:0]   set_b_tag;
   logic [ILS_COUNT_WIDTH-1:0] set_b_count;
   logic [ILS_TAG_WIDTH-1:0]   query_a_tag;
   logic [ILS_TAG_WIDTH-1:0]   query_b_tag;
   logic [ILS_TAG_WIDTH-1:0]   query_c_tag;
   logic                       query_a_busy;
   logic                       query_b_busy;
   logic                       query_c_busy;
   logic [ILS_REG_COUNT-1:0]   busy_map;

   modport sched
   (
      output set_a_valid, set_a_tag, set_a_count,
      output set_b_valid, set_b_tag, set_b_count,
      output query_a_tag, query_b_tag, query_c_tag,
      input  query_a_busy, query_b_busy, query_c_busy, busy_map
   );

   modport board
   (
      input  set_a_valid, set_a_tag, set_a_count,
      input  set_b_valid, set_b_tag, set_b_count,
      input  query_a_tag, query_b_tag, query_c_tag,
      output query_a_busy, query_b_busy, query_c_busy, busy_map
   );
endinterface

`default_nettype wire

/* File: verilog/ils_busy_timer.sv */
// Countdown that keeps a nonpipelined resource busy for a loaded interval.
// Assumes start is a one-cycle pulse taken only while idle.

`timescale 1ns/1ps
`default_nettype none

module ils_busy_timer
   import ils_pkg::*;
(
   input  wire logic                       core_clk,
   input  wire logic                       reset,
   input  wire logic                       start,
   input  wire logic [ILS_COUNT_WIDTH-1:0] length,
   output var  logic                       busy
);
   logic [ILS_COUNT_WIDTH-1:0] count;

   assign busy = (count != ILS_COUNT_RESET);

   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
         count <= ILS_COUNT_RESET;
      else if (start)
         count <= length;
      else if (busy)
         count <= count - 6'h01;
   end
endmodule

`default_nettype wire

/* File: verilog/ils_scoreboard.sv */
// Per-register countdown of cycles until an in-flight result is usable.
// Assumes a count of zero means ready; two writes per cycle are allowed.

`timescale 1ns/1ps
`default_nettype none

module ils_scoreboard
   import ils_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic reset,
   ils_board_if.board board
);
   logic [ILS_COUNT_WIDTH-1:0] remain [ILS_REG_COUNT];
   logic [ILS_REG_COUNT-1:0]   busy;

   always_comb
   begin
      for (int i = 0; i < ILS_REG_COUNT; i++)
         busy[i] = (remain[i] != ILS_COUNT_RESET);
   end

   assign board.busy_map     = busy;
   assign board.query_a_busy = busy[board.query_a_tag];
   assign board.query_b_busy = busy[board.query_b_tag];
   assign board.query_c_busy = busy[board.query_c_tag];

   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         for (int i = 0; i < ILS_REG_COUNT; i++)
            remain[i] <= ILS_COUNT_RESET;
      end
      else
      begin
         for (int i = 0; i < ILS_REG_COUNT; i++)
         begin
            if (board.set_a_valid && board.set_a_tag == ILS_TAG_WIDTH'(i))
               remain[i] <= board.set_a_count;
            else if (board.set_b_valid && board.set_b_tag == ILS_TAG_WIDTH'(i))
               remain[i] <= board.set_b_count;
            else if (busy[i])
               remain[i] <= remain[i] - 6'h01;
         end
      end
   end
endmodule

`default_nettype wire

/* File: verilog/issue_latency_scheduler.sv */
// Issue and latency control for moves, floating-point memory and simple
// floating-point arithmetic. Routes each dispatched operation to its units.
// Assumes dispatch holds an operation until dispatch_ready is seen high.

`timescale 1ns/1ps
`default_nettype none

module issue_latency_scheduler
   import ils_pkg::*;
#(
   parameter int SPECIAL_LATENCY = ILS_LAT_SPECIAL_READ,
   parameter int TIME_BASE_GAP   = ILS_GAP_TIME_BASE
)
(
   input  wire logic                      core_clk,
   input  wire logic                      reset,
   input  wire logic                      dispatch_valid,
   input  wire ils_op_type                dispatch_op,
   input  wire logic                      dispatch_bit11,
   input  wire logic                      src_a_valid,
   input  wire logic [ILS_TAG_WIDTH-1:0]  src_a_tag,
   input  wire logic                      src_b_valid,
   input  wire logic [ILS_TAG_WIDTH-1:0]  src_b_tag,
   input  wire logic                      gpr_dest_valid,
   input  wire logic [4:0]                gpr_dest,
   input  wire logic                      fpr_dest_valid,
   input  wire logic [4:0]                fpr_dest,
   output logic                           dispatch_ready,
   output logic                           issued,
   output ils_op_type                     issued_op,
   output logic [ILS_UNIT_COUNT-1:0]      unit_issue,
   output logic [ILS_UNIT_COUNT-1:0]      unit_exec,
   output logic                           fixed_unit_select,
   output logic                           pipeline_stall,
   output logic [ILS_REG_COUNT-1:0]       reg_busy
);

   // ***********************************************************************
   // Helper functions
   // ***********************************************************************

   // Latency in cycles to the blocking count held in the scoreboard
   function automatic logic [ILS_COUNT_WIDTH-1:0] lat_count(input int lat);
      lat_count = ILS_COUNT_WIDTH'(lat - 1);
   endfunction

   function automatic logic [ILS_TAG_WIDTH-1:0] gpr_tag(input logic [4:0] r);
      gpr_tag = {1'b0, r};
   endfunction

   function automatic logic [ILS_TAG_WIDTH-1:0] fpr_tag(input logic [4:0] r);
      fpr_tag = {1'b1, r};
   endfunction

   // ***********************************************************************
   // Submodules
   // ***********************************************************************
   ils_board_if board ();

   logic cond_busy;
   logic time_busy;
   logic special_busy;
   logic start_cond;
   logic start_time;
   logic start_special;

   ils_scoreboard u_board
   (
      .core_clk (core_clk),
      .reset    (reset),
      .board    (board.board)
   );

   ils_busy_timer u_cond_timer
   (
      .core_clk (core_clk),
      .reset    (reset),
      .start    (start_cond),
      .length   (lat_count(ILS_GAP_COND_READ)),
      .busy     (cond_busy)
   );

   ils_busy_timer u_time_timer
   (
      .core_clk (core_clk),
      .reset    (reset),
      .start    (start_time),
      .length   (lat_count(TIME_BASE_GAP)),
      .busy     (time_busy)
   );

   ils_busy_timer u_special_timer
   (
      .core_clk (core_clk),
      .reset    (reset),
      .start    (start_special),
      .length   (lat_count(SPECIAL_LATENCY)),
      .busy     (special_busy)
   );

   // ***********************************************************************
   // Operation decode
   // ***********************************************************************
   wire op_link    = (dispatch_op == ILS_OP_LINK_COUNT_MOVE);
   wire op_xer     = (dispatch_op == ILS_OP_XER_TO_COND);
   wire op_cond    = (dispatch_op == ILS_OP_COND_READ);
   wire op_time    = (dispatch_op == ILS_OP_TIME_BASE_READ);
   wire op_special = (dispatch_op == ILS_OP_SPECIAL_READ);
   wire op_load    = (dispatch_op == ILS_OP_FP_LOAD);
   wire op_load_u  = (dispatch_op == ILS_OP_FP_LOAD_UPDATE);
   wire op_store   = (dispatch_op == ILS_OP_FP_STORE);
   wire op_store_u = (dispatch_op == ILS_OP_FP_STORE_UPDATE);
   wire op_st_int  = (dispatch_op == ILS_OP_FP_STORE_INT);
   wire op_arith   = (dispatch_op == ILS_OP_FP_ARITH);

   // Field form is the nonpipelined variant; both forms hold the timer
   wire cond_field = op_cond && dispatch_bit11;

   // Units that receive a copy of the operation
   wire [ILS_UNIT_COUNT-1:0] next_issue_units;
   assign next_issue_units[ILS_UNIT_BRANCH] = op_link || op_xer || op_cond;
   assign next_issue_units[ILS_UNIT_FIXED]  = op_time || op_special
                                            || op_load_u || op_store_u;
   assign next_issue_units[ILS_UNIT_LSU]    = op_load || op_load_u || op_store
                                            || op_store_u || op_st_int;
   assign next_issue_units[ILS_UNIT_FLOAT]  = op_load || op_load_u || op_store
                                            || op_store_u || op_st_int
                                            || op_arith;

   // Units that really do work; a plain float load is only a copy to float
   wire [ILS_UNIT_COUNT-1:0] next_exec_units;
   assign next_exec_units[ILS_UNIT_BRANCH] = next_issue_units[ILS_UNIT_BRANCH];
   assign next_exec_units[ILS_UNIT_FIXED]  = next_issue_units[ILS_UNIT_FIXED];
   assign next_exec_units[ILS_UNIT_LSU]    = next_issue_units[ILS_UNIT_LSU];
   assign next_exec_units[ILS_UNIT_FLOAT]  = next_issue_units[ILS_UNIT_FLOAT]
                                           && !op_load;

   // ***********************************************************************
   // Result latencies per destination file
   // ***********************************************************************
   logic                       gpr_writes;
   logic [ILS_COUNT_WIDTH-1:0] gpr_count;
   logic                       fpr_writes;
   logic [ILS_COUNT_WIDTH-1:0] fpr_count;

   always_comb
   begin
      gpr_writes = 1'b0;
      gpr_count  = ILS_COUNT_RESET;
      fpr_writes = 1'b0;
      fpr_count  = ILS_COUNT_RESET;
      unique case (dispatch_op)
         ILS_OP_LINK_COUNT_MOVE:
         begin
            gpr_writes = gpr_dest_valid;
            gpr_count  = lat_count(ILS_LAT_LINK_COUNT);
         end
         ILS_OP_XER_TO_COND:
         begin
            gpr_writes = 1'b0;
            gpr_count  = lat_count(ILS_LAT_XER_TO_COND);
         end
         ILS_OP_COND_READ:
         begin
            gpr_writes = gpr_dest_valid;
            gpr_count  = lat_count(ILS_LAT_COND_READ);
         end
         ILS_OP_TIME_BASE_READ:
         begin
            gpr_writes = gpr_dest_valid;
            gpr_count  = lat_count(ILS_LAT_TIME_BASE);
         end
         ILS_OP_SPECIAL_READ:
         begin
            gpr_writes = gpr_dest_valid;
            gpr_count  = lat_count(SPECIAL_LATENCY);
         end
         ILS_OP_FP_LOAD:
         begin
            fpr_writes = fpr_dest_valid;
            fpr_count  = lat_count(ILS_LAT_FP_LOAD);
         end
         ILS_OP_FP_LOAD_UPDATE:
         begin
            fpr_writes = fpr_dest_valid;
            fpr_count  = lat_count(ILS_LAT_FP_LOAD);
            gpr_writes = gpr_dest_valid;
            gpr_count  = lat_count(ILS_LAT_UPDATE_GPR);
         end
         ILS_OP_FP_STORE_UPDATE:
         begin
            gpr_writes = gpr_dest_valid;
            gpr_count  = lat_count(ILS_LAT_UPDATE_GPR);
         end
         ILS_OP_FP_ARITH:
         begin
            fpr_writes = fpr_dest_valid;
            fpr_count  = lat_count(ILS_LAT_FP_ARITH);
         end
         ILS_OP_NONE, ILS_OP_FP_STORE, ILS_OP_FP_STORE_INT:
         begin
            gpr_writes = 1'b0;
            fpr_writes = 1'b0;
         end
         default:
         begin
            gpr_writes = 1'b0;
            fpr_writes = 1'b0;
         end
      endcase
   end

   // ***********************************************************************
   // Hazard checks and issue decision
   // ***********************************************************************
   assign board.query_a_tag = src_a_tag;
   assign board.query_b_tag = src_b_tag;
   assign board.query_c_tag = gpr_tag(gpr_dest);

   wire fpr_dest_busy = board.busy_map[fpr_tag(fpr_dest)];

   // Sources wait for in-flight results; destinations wait to keep order
   wire data_hazard = (src_a_valid && board.query_a_busy)
                    || (src_b_valid && board.query_b_busy)
                    || (gpr_writes && board.query_c_busy)
                    || (fpr_writes && fpr_dest_busy);

   // Nonpipelined resources refuse a second operation while busy
   wire unit_hazard = (op_cond && cond_busy)
                    || (op_time && time_busy);

   // A pending special read holds every later operation
   wire stall_all = special_busy;

   wire known_op = (dispatch_op != ILS_OP_NONE);
   wire take     = dispatch_valid && known_op && !data_hazard
                 && !unit_hazard && !stall_all;

   assign dispatch_ready = !data_hazard && !unit_hazard && !stall_all;

   assign start_cond    = take && op_cond;
   assign start_time    = take && op_time;
   assign start_special = take && op_special;

   assign board.set_a_valid = take && gpr_writes && (gpr_count != ILS_COUNT_RESET);
   assign board.set_a_tag   = gpr_tag(gpr_dest);
   assign board.set_a_count = gpr_count;
   assign board.set_b_valid = take && fpr_writes && (fpr_count != ILS_COUNT_RESET);
   assign board.set_b_tag   = fpr_tag(fpr_dest);
   assign board.set_b_count = fpr_count;

   // Time base reads always use fixed unit 0; others alternate
   logic fixed_toggle;
   wire  next_fixed_select = op_time ? 1'b0 : fixed_toggle;
   wire  uses_fixed        = take && next_issue_units[ILS_UNIT_FIXED];

   // ***********************************************************************
   // Registered outputs
   // ***********************************************************************
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         issued            <= 1'b0;
         issued_op         <= ILS_OP_NONE;
         unit_issue        <= ILS_UNIT_RESET;
         unit_exec         <= ILS_UNIT_RESET;
         fixed_unit_select <= 1'b0;
         fixed_toggle      <= 1'b0;
      end
      else
      begin
         issued            <= take;
         issued_op         <= take ? dispatch_op : ILS_OP_NONE;
         unit_issue        <= take ? next_issue_units : ILS_UNIT_RESET;
         unit_exec         <= take ? next_exec_units : ILS_UNIT_RESET;
         fixed_unit_select <= uses_fixed ? next_fixed_select : 1'b0;
         if (uses_fixed && !op_time)
            fixed_toggle <= !fixed_toggle;
      end
   end

   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         pipeline_stall <= 1'b0;
         reg_busy       <= {ILS_REG_COUNT{1'b0}};
      end
      else
      begin
         pipeline_stall <= stall_all || start_special;
         reg_busy       <= board.busy_map;
      end
   end

   // Field form flag is decoded but both forms share the same timer
   wire unused_field = cond_field;

endmodule

`default_nettype wire

/* File: verif/ils_sched_assertions.sv */
// Concurrent checks on the scheduler's top-level ports.
// Assumes one core clock and an asynchronous active-high reset.

`timescale 1ns/1ps
`default_nettype none

module ils_sched_assertions
   import ils_pkg::*;
#(
   parameter int SPECIAL_LATENCY = ILS_LAT_SPECIAL_READ,
   parameter int TIME_BASE_GAP   = ILS_GAP_TIME_BASE
)
(
   input wire logic        core_clk,
   input wire logic        reset,
   input wire logic        dispatch_valid,
   input wire ils_op_type  dispatch_op,
   input wire logic        dispatch_bit11,
   input wire logic        src_a_valid,
   input wire logic [5:0]  src_a_tag,
   input wire logic        src_b_valid,
   input wire logic [5:0]  src_b_tag,
   input wire logic        gpr_dest_valid,
   input wire logic [4:0]  gpr_dest,
   input wire logic        fpr_dest_valid,
   input wire logic [4:0]  fpr_dest,
   input wire logic        dispatch_ready,
   input wire logic        issued,
   input wire ils_op_type  issued_op,
   input wire logic [3:0]  unit_issue,
   input wire logic [3:0]  unit_exec,
   input wire logic        fixed_unit_select,
   input wire logic        pipeline_stall,
   input wire logic [63:0] reg_busy
);
   // ********
   // Cycles since the last take of each spaced class
   // ********
   logic       take;
   logic       cond_take;
   logic       tb_take;
   logic       sp_take;
   logic [5:0] cond_age;
   logic [5:0] tb_age;
   logic [5:0] sp_age;

   assign take      = dispatch_valid && dispatch_ready && (dispatch_op != ILS_OP_NONE);
   assign cond_take = take && (dispatch_op == ILS_OP_COND_READ);
   assign tb_take   = take && (dispatch_op == ILS_OP_TIME_BASE_READ);
   assign sp_take   = take && (dispatch_op == ILS_OP_SPECIAL_READ);

   function automatic logic [5:0] next_age(input logic [5:0] a, input logic hit);
      return hit ? 6'h01 : ((a == 6'h3F) ? a : a + 6'h01);
   endfunction

   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         cond_age <= 6'h3F;
         tb_age   <= 6'h3F;
         sp_age   <= 6'h3F;
      end
      else
      begin
         cond_age <= next_age(cond_age, cond_take);
         tb_age   <= next_age(tb_age, tb_take);
         sp_age   <= next_age(sp_age, sp_take);
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   issue_after_take_a: assert property (take |=> issued && issued_op == $past(dispatch_op))
      else $error("issue pulse missing after take");
   no_spurious_a: assert property (!take |=> !issued && unit_issue == 4'h0)
      else $error("issue without take");
   branch_ops_a: assert property (take && (dispatch_op inside {ILS_OP_LINK_COUNT_MOVE,
      ILS_OP_XER_TO_COND, ILS_OP_COND_READ}) |=> unit_issue == 4'h1 && unit_exec == 4'h1)
      else $error("branch class routed wrongly");
   cond_spacing_a: assert property (cond_take |-> cond_age >= 6'h22)
      else $error("condition read taken too soon");
   time_base_a: assert property (tb_take |=> unit_exec == 4'h2 && !fixed_unit_select)
      else $error("time base read misrouted");
   tb_spacing_a: assert property (tb_take |-> tb_age >= TIME_BASE_GAP)
      else $error("time base read taken too soon");
   special_stall_a: assert property (sp_take |=> pipeline_stall && !dispatch_ready)
      else $error("special read did not stall");
   special_block_a: assert property (take |-> sp_age >= SPECIAL_LATENCY)
      else $error("take during special read");
   fp_load_a: assert property (take && dispatch_op == ILS_OP_FP_LOAD |=>
      unit_issue == 4'hC && unit_exec == 4'h4)
      else $error("float load routed wrongly");
   update_units_a: assert property (take && (dispatch_op inside {ILS_OP_FP_LOAD_UPDATE,
      ILS_OP_FP_STORE_UPDATE}) |=> unit_issue == 4'hE)
      else $error("update form missing a unit");
   plain_store_a: assert property (take && (dispatch_op inside {ILS_OP_FP_STORE,
      ILS_OP_FP_STORE_INT}) |=> unit_issue == 4'hC)
      else $error("store routed wrongly");
   fp_arith_a: assert property (take && dispatch_op == ILS_OP_FP_ARITH |=> unit_exec == 4'h8)
      else $error("arithmetic routed wrongly");
endmodule

bind issue_latency_scheduler ils_sched_assertions #(.SPECIAL_LATENCY(SPECIAL_LATENCY),
   .TIME_BASE_GAP(TIME_BASE_GAP)) checks (.core_clk, .reset, .dispatch_valid, .dispatch_op,
   .dispatch_bit11, .src_a_valid, .src_a_tag, .src_b_valid, .src_b_tag, .gpr_dest_valid,
   .gpr_dest, .fpr_dest_valid, .fpr_dest, .dispatch_ready, .issued, .issued_op, .unit_issue,
   .unit_exec, .fixed_unit_select, .pipeline_stall, .reg_busy);

`default_nettype wire

/* File: verif/ils_testbench.sv */
// Self-checking bench for the issue and latency scheduler.
// Assumes the package, interface and design files are compiled first.

`timescale 1ns/1ps
`default_nettype none

module testbench
   import ils_pkg::*;
;
   localparam int SP_LAT = 8;
   localparam int TB_GAP = 40;

   logic        core_clk = 1'b0;
   logic        reset = 1'b1;
   logic        dispatch_valid = 1'b0;
   ils_op_type  dispatch_op = ILS_OP_NONE;
   logic        dispatch_bit11 = 1'b0;
   logic        src_a_valid = 1'b0;
   logic [5:0]  src_a_tag = 6'h00;
   logic        src_b_valid = 1'b0;
   logic [5:0]  src_b_tag = 6'h00;
   logic        gpr_dest_valid = 1'b0;
   logic [4:0]  gpr_dest = 5'h00;
   logic        fpr_dest_valid = 1'b0;
   logic [4:0]  fpr_dest = 5'h00;
   logic        dispatch_ready;
   logic        issued;
   ils_op_type  issued_op;
   logic [3:0]  unit_issue;
   logic [3:0]  unit_exec;
   logic        fixed_unit_select;
   logic        pipeline_stall;
   logic [63:0] reg_busy;
   int          mismatches = 0;
   int          compares = 0;
   int          cycles = 0;
   int          w;
   logic [31:0] seed = 32'h195E;
   logic        prev_take = 1'b0;
   ils_op_type  prev_op = ILS_OP_NONE;
   ils_op_type  sop;
   ils_op_type  ops [8] = '{ILS_OP_LINK_COUNT_MOVE, ILS_OP_XER_TO_COND, ILS_OP_FP_LOAD,
      ILS_OP_FP_STORE, ILS_OP_FP_STORE_UPDATE, ILS_OP_FP_STORE_INT, ILS_OP_FP_ARITH,
      ILS_OP_FP_LOAD_UPDATE};
   ils_op_type  dop [5] = '{ILS_OP_FP_ARITH, ILS_OP_FP_LOAD_UPDATE, ILS_OP_FP_LOAD_UPDATE,
      ILS_OP_FP_STORE_UPDATE, ILS_OP_FP_LOAD};
   logic [4:0]  ddst [5] = '{5'h03, 5'h07, 5'h0A, 5'h0C, 5'h06};
   logic [5:0]  dsrc [5] = '{6'h23, 6'h07, 6'h2A, 6'h0C, 6'h26};
   logic [7:0]  dexp [5] = '{8'h09, 8'h01, 8'h00, 8'h01, 8'h00};

   issue_latency_scheduler #(.SPECIAL_LATENCY(SP_LAT), .TIME_BASE_GAP(TB_GAP)) dut
   (
      .core_clk, .reset, .dispatch_valid, .dispatch_op, .dispatch_bit11, .src_a_valid,
      .src_a_tag, .src_b_valid, .src_b_tag, .gpr_dest_valid, .gpr_dest, .fpr_dest_valid,
      .fpr_dest, .dispatch_ready, .issued, .issued_op, .unit_issue, .unit_exec,
      .fixed_unit_select, .pipeline_stall, .reg_busy
   );

   always #4 core_clk = ~core_clk;

   // ********
   // Helpers
   // ********
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [3:0] exp_units(input ils_op_type op, input logic ex);
      case (op)
         ILS_OP_LINK_COUNT_MOVE, ILS_OP_XER_TO_COND, ILS_OP_COND_READ: return 4'h1;
         ILS_OP_TIME_BASE_READ, ILS_OP_SPECIAL_READ: return 4'h2;
         ILS_OP_FP_LOAD: return ex ? 4'h4 : 4'hC;
         ILS_OP_FP_STORE, ILS_OP_FP_STORE_INT: return 4'hC;
         ILS_OP_FP_LOAD_UPDATE, ILS_OP_FP_STORE_UPDATE: return 4'hE;
         default: return 4'h8;
      endcase
   endfunction

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Holds the offer until it is taken; waited counts refused cycles
   task automatic offer(input ils_op_type op, input logic b11, input logic [6:0] sa,
                        input logic [6:0] sb, input logic [5:0] gd, input logic [5:0] fd,
                        output int waited);
      dispatch_valid <= 1'b1;
      dispatch_op <= op;
      dispatch_bit11 <= b11;
      {src_a_valid, src_a_tag} <= sa;
      {src_b_valid, src_b_tag} <= sb;
      {gpr_dest_valid, gpr_dest} <= gd;
      {fpr_dest_valid, fpr_dest} <= fd;
      waited = 0;
      @(negedge core_clk);
      while (dispatch_ready !== 1'b1)
      begin
         waited++;
         @(negedge core_clk);
      end
      @(posedge core_clk);
   endtask

   // ********
   // Output monitor
   // ********
   always @(negedge core_clk)
   begin
      if (!reset)
      begin
         check(8'(issued), 8'(prev_take));
         if (prev_take)
         begin
            check(8'(unit_issue), 8'(exp_units(prev_op, 1'b0)));
            check(8'(unit_exec), 8'(exp_units(prev_op, 1'b1)));
            check(8'(issued_op), 8'(prev_op));
            if (prev_op == ILS_OP_TIME_BASE_READ)
               check(8'(fixed_unit_select), 8'h00);
            if (prev_op == ILS_OP_SPECIAL_READ)
               check(8'(pipeline_stall), 8'h01);
         end
      end
      prev_take = !reset && dispatch_valid && dispatch_ready === 1'b1 && dispatch_op != ILS_OP_NONE;
      prev_op = dispatch_op;
   end

   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         finish_test();
      end
   end

   // ********
   // Main sequence
   // ********
   initial
   begin
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      for (int i = 0; i < 16; i++)
      begin
         offer(ops[i % 8], 1'b0, 7'h00, 7'h00, {1'b1, 5'(i)}, {1'b1, 5'(i)}, w);
         check(8'(w), 8'h00);
      end
      for (int i = 0; i < 3; i++)
      begin
         sop = (i == 2) ? ILS_OP_TIME_BASE_READ : ILS_OP_COND_READ;
         offer(sop, i[0], 7'h00, 7'h00, 6'h00, 6'h00, w);
         offer(sop, i[0], 7'h00, 7'h00, 6'h00, 6'h00, w);
         check(8'(w), (i == 2) ? 8'(TB_GAP - 1) : 8'h21);
      end
      offer(ILS_OP_SPECIAL_READ, 1'b0, 7'h00, 7'h00, 6'h00, 6'h00, w);
      offer(ILS_OP_LINK_COUNT_MOVE, 1'b0, 7'h00, 7'h00, 6'h00, 6'h00, w);
      check(8'(w), 8'(SP_LAT - 1));
      for (int i = 0; i < 5; i++)
      begin
         offer(dop[i], 1'b0, 7'h00, 7'h00, {1'b1, ddst[i]}, {1'b1, ddst[i]}, w);
         offer(ILS_OP_FP_STORE, 1'b0, {1'b1, dsrc[i]}, 7'h00, 6'h00, 6'h00, w);
         check(8'(w), dexp[i]);
      end
      // Busy map shows an in-flight float result one cycle late
      offer(ILS_OP_FP_ARITH, 1'b0, 7'h00, 7'h00, 6'h00, 6'h3F, w);
      dispatch_valid <= 1'b0;
      repeat (2) @(negedge core_clk);
      check(8'(reg_busy[63]), 8'h01);
      @(posedge core_clk);
      for (int i = 0; i < 300; i++)
      begin
         seed = lfsr(seed);
         offer(ils_op_type'(4'h1 + 4'(seed % 11)), seed[4], seed[11:5], seed[18:12],
               seed[24:19], seed[30:25], w);
      end
      dispatch_valid <= 1'b0;
      dispatch_op <= ILS_OP_NONE;
      repeat (48) @(negedge core_clk);
      check(8'(|reg_busy), 8'h00);
      finish_test();
   end
endmodule

`default_nettype wire
